// ===== hw/time_of_day_clock_service.sv
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
module time_of_day_clock_service #(
    parameter int TICK_PERIOD = tod_pkg::TICK_CYCLES,
    parameter int SEC_PERIOD = tod_pkg::SEC_CYCLES,
    // ticks that make one day; a small value lets the day rollover be reached quickly
    parameter logic [31:0] DAY_TICKS = tod_pkg::TICKS_PER_DAY
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic alarm_event,
    output logic tick_hook_event
);
    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] tick;
        logic [31:0] day_ticks;
        logic overflow;
        logic [7:0] days;
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
        logic [7:0] century;
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] day;
        logic armed;
        logic [7:0] al_hours;
        logic [7:0] al_minutes;
        logic [7:0] al_seconds;
        logic [15:0] arg_hi;
        logic [15:0] arg_lo;
        logic reject;
        logic [7:0] res_flag;
        logic [15:0] res_hi;
        logic [15:0] res_lo;
        logic alarm;
        logic hook;
        logic [31:0] rdata;
    } tod_s;
    tod_s st_ff;
    tod_s nxt_st;

    logic tick_pulse;
    logic sec_pulse;
    logic [7:0] sec_n, min_n, hr_n;
    logic sec_c, min_c, hr_c;
    logic addr_ok;

    // ***********************************************************
    // time bases
    // ***********************************************************
    tick_divider #(.PERIOD(TICK_PERIOD)) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .pulse(tick_pulse)
    );
    // calendar runs on its own second base; tick count need not divide evenly
    tick_divider #(.PERIOD(SEC_PERIOD)) u_sec (
        .hclk(hclk),
        .hresetn(hresetn),
        .pulse(sec_pulse)
    );

    // bcd ripple for the time of day
    bcd_digit_pair u_s (.value(st_ff.seconds), .limit(8'h59), .wrap_to(8'h00),
        .next_value(sec_n), .carry(sec_c));
    bcd_digit_pair u_m (.value(st_ff.minutes), .limit(8'h59), .wrap_to(8'h00),
        .next_value(min_n), .carry(min_c));
    bcd_digit_pair u_h (.value(st_ff.hours), .limit(8'h23), .wrap_to(8'h00),
        .next_value(hr_n), .carry(hr_c));

    // ***********************************************************
    // bus decode
    // ***********************************************************
    function automatic logic is_reg(input logic [7:0] a);
        is_reg = (a == tod_pkg::OFS_CMD) || (a == tod_pkg::OFS_ARG_HI) ||
            (a == tod_pkg::OFS_ARG_LO) || (a == tod_pkg::OFS_RES_FLAG) ||
            (a == tod_pkg::OFS_RES_HI) || (a == tod_pkg::OFS_RES_LO) ||
            (a == tod_pkg::OFS_STATUS);
    endfunction

    assign addr_ok = hsel && hready && htrans[1];

    // ***********************************************************
    // next state
    // ***********************************************************
    // commands take effect in the write data phase; the free-running
    // counters update in the same cycle, commands win over counting
    always_comb begin
        nxt_st = st_ff;
        nxt_st.alarm = 1'b0;
        nxt_st.hook = 1'b0;
        // unmapped writes never become pending, so they cannot reach the command decode
        nxt_st.wr_pend = addr_ok && hwrite && is_reg(haddr[7:0]);
        if (addr_ok) begin
            nxt_st.wr_addr = haddr[7:0];
        end

        // tick count and day accounting
        if (tick_pulse) begin
            nxt_st.tick = st_ff.tick + 32'h0000_0001;
            nxt_st.hook = 1'b1;
            if (st_ff.day_ticks >= DAY_TICKS - 32'h0000_0001) begin
                nxt_st.day_ticks = 32'h0000_0000;
                nxt_st.overflow = 1'b1;
                if (st_ff.days != tod_pkg::DAYS_MAX) begin
                    nxt_st.days = st_ff.days + 8'h01;
                end
            end else begin
                nxt_st.day_ticks = st_ff.day_ticks + 32'h0000_0001;
            end
        end

        // calendar time of day
        if (sec_pulse) begin
            nxt_st.seconds = sec_n;
            if (sec_c) begin
                nxt_st.minutes = min_n;
                if (min_c) begin
                    nxt_st.hours = hr_n;
                end
            end
        end

        // alarm compare, single shot
        if (st_ff.armed && st_ff.hours == st_ff.al_hours &&
            st_ff.minutes == st_ff.al_minutes && st_ff.seconds == st_ff.al_seconds) begin
            nxt_st.alarm = 1'b1;
            nxt_st.armed = 1'b0;
        end

        // register writes
        if (st_ff.wr_pend) begin
            case (st_ff.wr_addr)
                tod_pkg::OFS_ARG_HI: nxt_st.arg_hi = hwdata[15:0];
                tod_pkg::OFS_ARG_LO: nxt_st.arg_lo = hwdata[15:0];
                tod_pkg::OFS_CMD: begin
                    case (hwdata[7:0])
                        tod_pkg::FC_READ_TICK, tod_pkg::FC_READ_DAYS: begin
                            nxt_st.res_flag = (hwdata[7:0] == tod_pkg::FC_READ_DAYS) ?
                                st_ff.days : {7'h00, st_ff.overflow};
                            nxt_st.res_hi = st_ff.tick[31:16];
                            nxt_st.res_lo = st_ff.tick[15:0];
                            nxt_st.overflow = 1'b0;
                            nxt_st.days = 8'h00;
                            nxt_st.day_ticks = 32'h0000_0000;
                        end
                        tod_pkg::FC_SET_TICK: begin
                            nxt_st.tick = {st_ff.arg_hi, st_ff.arg_lo};
                            nxt_st.overflow = 1'b0;
                            nxt_st.days = 8'h00;
                            nxt_st.day_ticks = 32'h0000_0000;
                        end
                        tod_pkg::FC_READ_TIME: begin
                            nxt_st.res_hi = {st_ff.hours, st_ff.minutes};
                            nxt_st.res_lo = {st_ff.seconds, 8'h00};
                        end
                        tod_pkg::FC_SET_TIME: begin
                            nxt_st.hours = st_ff.arg_hi[15:8];
                            nxt_st.minutes = st_ff.arg_hi[7:0];
                            nxt_st.seconds = st_ff.arg_lo[15:8];
                        end
                        tod_pkg::FC_READ_DATE: begin
                            nxt_st.res_hi = {st_ff.century, st_ff.year};
                            nxt_st.res_lo = {st_ff.month, st_ff.day};
                        end
                        tod_pkg::FC_SET_DATE: begin
                            nxt_st.century = st_ff.arg_hi[15:8];
                            nxt_st.year = st_ff.arg_hi[7:0];
                            nxt_st.month = st_ff.arg_lo[15:8];
                            nxt_st.day = st_ff.arg_lo[7:0];
                        end
                        tod_pkg::FC_SET_ALARM: begin
                            if (st_ff.armed) begin
                                nxt_st.reject = 1'b1;
                            end else begin
                                nxt_st.reject = 1'b0;
                                nxt_st.armed = 1'b1;
                                nxt_st.al_hours = st_ff.arg_hi[15:8];
                                nxt_st.al_minutes = st_ff.arg_hi[7:0];
                                nxt_st.al_seconds = st_ff.arg_lo[15:8];
                            end
                        end
                        tod_pkg::FC_CANCEL_ALARM: nxt_st.armed = 1'b0;
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end

        // read data, registered for the data phase
        nxt_st.rdata = 32'h0000_0000;
        if (addr_ok && !hwrite && is_reg(haddr[7:0])) begin
            case (haddr[7:0])
                tod_pkg::OFS_ARG_HI: nxt_st.rdata = {16'h0000, st_ff.arg_hi};
                tod_pkg::OFS_ARG_LO: nxt_st.rdata = {16'h0000, st_ff.arg_lo};
                tod_pkg::OFS_RES_FLAG: nxt_st.rdata = {23'h000000, st_ff.reject, st_ff.res_flag};
                tod_pkg::OFS_RES_HI: nxt_st.rdata = {16'h0000, st_ff.res_hi};
                tod_pkg::OFS_RES_LO: nxt_st.rdata = {16'h0000, st_ff.res_lo};
                tod_pkg::OFS_STATUS: nxt_st.rdata = {31'h00000000, st_ff.armed};
                default: nxt_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ***********************************************************
    // state register
    // ***********************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
            st_ff.century <= tod_pkg::CENTURY_RESET;
            st_ff.month <= tod_pkg::MONTH_RESET;
            st_ff.day <= tod_pkg::DAY_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // zero-wait slave, unmapped addresses read zero and ignore writes
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_ff.rdata;
    assign alarm_event = st_ff.alarm;
    assign tick_hook_event = st_ff.hook;

    // ***********************************************************
    // checks
    // ***********************************************************
    a_tick_hook: assert property (@(posedge hclk) disable iff (!hresetn)
        tick_pulse |=> tick_hook_event) else $error("tick hook missing");
    a_days_sat: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.days == tod_pkg::DAYS_MAX && !st_ff.wr_pend |=> st_ff.days == tod_pkg::DAYS_MAX)
        else $error("days wrapped");
    a_reject_keep: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.wr_pend && st_ff.wr_addr == tod_pkg::OFS_CMD && hwdata[7:0] == tod_pkg::FC_SET_ALARM
        && st_ff.armed && !alarm_event |=> st_ff.reject && $stable(st_ff.al_hours))
        else $error("alarm overwritten");
    a_clear_read: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.wr_pend && st_ff.wr_addr == tod_pkg::OFS_CMD && hwdata[7:0] == tod_pkg::FC_READ_TICK
        |=> !st_ff.overflow && st_ff.days == 8'h00) else $error("flag not cleared");
    a_alarm_once: assert property (@(posedge hclk) disable iff (!hresetn)
        alarm_event |-> !st_ff.armed) else $error("alarm still armed");
    a_cancel_arm: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.wr_pend && st_ff.wr_addr == tod_pkg::OFS_CMD
        && hwdata[7:0] == tod_pkg::FC_CANCEL_ALARM |=> !st_ff.armed) else $error("cancel failed");
    a_tick_count: assert property (@(posedge hclk) disable iff (!hresetn)
        tick_pulse && !st_ff.wr_pend |=> st_ff.tick == $past(st_ff.tick) + 32'h0000_0001)
        else $error("tick not advanced");
    a_ovf_day: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(st_ff.overflow) |-> st_ff.day_ticks == 32'h0000_0000) else $error("early overflow");
    // a day boundary with no command in flight steps the days count by one while it is below DAYS_MAX
    a_days_step: assert property (@(posedge hclk) disable iff (!hresetn)
        tick_pulse && st_ff.day_ticks >= DAY_TICKS - 32'h0000_0001
        && st_ff.days != tod_pkg::DAYS_MAX && !st_ff.wr_pend
        |=> st_ff.days == $past(st_ff.days) + 8'h01) else $error("day not counted");
    // command results, seen one edge after the command's data phase
    a_set_tick: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.wr_pend && st_ff.wr_addr == tod_pkg::OFS_CMD && hwdata[7:0] == tod_pkg::FC_SET_TICK
        |=> st_ff.tick == $past({st_ff.arg_hi, st_ff.arg_lo})) else $error("tick set lost");
    a_read_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.wr_pend && st_ff.wr_addr == tod_pkg::OFS_CMD && hwdata[7:0] == tod_pkg::FC_READ_TICK
        |=> st_ff.res_flag == {7'h00, $past(st_ff.overflow)}) else $error("flag result wrong");
    a_read_days: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.wr_pend && st_ff.wr_addr == tod_pkg::OFS_CMD && hwdata[7:0] == tod_pkg::FC_READ_DAYS
        |=> st_ff.res_flag == $past(st_ff.days)) else $error("days result wrong");
    a_accept_arm: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.wr_pend && st_ff.wr_addr == tod_pkg::OFS_CMD && hwdata[7:0] == tod_pkg::FC_SET_ALARM
        && !st_ff.armed |=> st_ff.armed && !st_ff.reject) else $error("alarm not accepted");
    a_time_write: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.wr_pend && st_ff.wr_addr == tod_pkg::OFS_CMD && hwdata[7:0] == tod_pkg::FC_SET_TIME
        |=> st_ff.hours == $past(st_ff.arg_hi[15:8]) && st_ff.seconds == $past(st_ff.arg_lo[15:8]))
        else $error("time write lost");
    a_date_write: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.wr_pend && st_ff.wr_addr == tod_pkg::OFS_CMD && hwdata[7:0] == tod_pkg::FC_SET_DATE
        |=> st_ff.century == $past(st_ff.arg_hi[15:8]) && st_ff.day == $past(st_ff.arg_lo[7:0]))
        else $error("date write lost");
endmodule

// ===== hw/tod_pkg.sv
package tod_pkg;
    // ***********************************************************
    // function codes
    // ***********************************************************
    localparam logic [7:0] FC_READ_TICK = 8'h00;
    localparam logic [7:0] FC_SET_TICK = 8'h01;
    localparam logic [7:0] FC_READ_TIME = 8'h02;
    localparam logic [7:0] FC_SET_TIME = 8'h03;
    localparam logic [7:0] FC_READ_DATE = 8'h04;
    localparam logic [7:0] FC_SET_DATE = 8'h05;
    localparam logic [7:0] FC_SET_ALARM = 8'h06;
    localparam logic [7:0] FC_CANCEL_ALARM = 8'h07;
    localparam logic [7:0] FC_READ_DAYS = 8'hd0;

    // ***********************************************************
    // register offsets (byte addresses)
    // ***********************************************************
    localparam logic [7:0] OFS_CMD = 8'h00;      // write: function code, starts it
    localparam logic [7:0] OFS_ARG_HI = 8'h04;   // [15:8] hours/century, [7:0] min/year
    localparam logic [7:0] OFS_ARG_LO = 8'h08;   // [15:8] sec/month, [7:0] day
    localparam logic [7:0] OFS_RES_FLAG = 8'h0c; // [8] reject status, [7:0] flag/days
    localparam logic [7:0] OFS_RES_HI = 8'h10;   // high result word
    localparam logic [7:0] OFS_RES_LO = 8'h14;   // low result word
    localparam logic [7:0] OFS_STATUS = 8'h18;   // [0] alarm armed

    // ***********************************************************
    // timing
    // ***********************************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_MILLIHZ = 18206480;      // 18.20648 Hz in micro-hertz units
    // cycles per tick, rounded down: 1e8 / 18.20648
    localparam int TICK_CYCLES = int'((64'(CLK_HZ) * 64'd1000000) / 64'(TICK_MILLIHZ));
    localparam int SEC_CYCLES = CLK_HZ;
    localparam logic [31:0] TICKS_PER_DAY = 32'h0018_00b0; // 1573040
    localparam logic [31:0] TICK_RESET = 32'h0000_0000;
    localparam logic [7:0] DAYS_MAX = 8'hff;
    localparam logic [7:0] BCD_RESET = 8'h00;
    localparam logic [7:0] CENTURY_RESET = 8'h19;
    localparam logic [7:0] MONTH_RESET = 8'h01;
    localparam logic [7:0] DAY_RESET = 8'h01;
endpackage

// ===== hw/bcd_digit_pair.sv
`timescale 1ns/100ps
// one bcd byte: increments with wrap at a limit and reports carry
module bcd_digit_pair (
    input wire logic [7:0] value,
    input wire logic [7:0] limit,
    input wire logic [7:0] wrap_to,
    output logic [7:0] next_value,
    output logic carry
);
    // ***********************************************************
    // increment
    // ***********************************************************
    // limit compare happens before increment so illegal values still wrap
    always_comb begin
        carry = (value >= limit);
        if (carry) begin
            next_value = wrap_to;
        end else if (value[3:0] >= 4'h9) begin
            next_value = {value[7:4] + 4'h1, 4'h0};
        end else begin
            next_value = {value[7:4], value[3:0] + 4'h1};
        end
    end
endmodule

// ===== hw/tick_divider.sv
`timescale 1ns/100ps
// free-running divider producing a one-cycle pulse every period cycles
module tick_divider #(
    parameter int PERIOD = 5492549
) (
    input wire logic hclk,
    input wire logic hresetn,
    output logic pulse
);
    typedef struct packed {
        logic [31:0] cnt;
        logic pulse;
    } div_s;
    div_s st_ff;
    div_s nxt_st;

    // ***********************************************************
    // counter
    // ***********************************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.pulse = 1'b0;
        if (st_ff.cnt >= 32'(PERIOD - 1)) begin
            nxt_st.cnt = 32'h0000_0000;
            nxt_st.pulse = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pulse = st_ff.pulse;
endmodule

// ===== testbench/time_of_day_clock_service_tb.sv
`timescale 1ns/100ps
module time_of_day_clock_service_tb;
    // short periods keep the run small; every expectation is derived from them
    localparam int TP = 20;
    localparam int SP = 200;
    // two ticks make a day, so day rollover and saturation are reachable
    localparam logic [31:0] DT = 32'h0000_0002;
    logic hclk, hresetn, hsel, hwrite, hready, hresp, hreadyout, alarm_event, tick_hook_event;
    logic [31:0] haddr, hwdata, hrdata, rd_v, hi_v, lo_v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int miscompares, cmp_count, hook_cnt, alarm_cnt, n;
    // ***********************************************************
    // compare macro
    // ***********************************************************
    `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
        $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
    time_of_day_clock_service #(.TICK_PERIOD(TP), .SEC_PERIOD(SP), .DAY_TICKS(DT)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .alarm_event(alarm_event),
        .tick_hook_event(tick_hook_event));
    // the single slave's ready is the bus ready
    assign hready = hreadyout;
    always #5 hclk = ~hclk;
    // event pulses stand one cycle, so they are counted on every edge
    always @(posedge hclk) begin
        if (tick_hook_event === 1'b1) hook_cnt++;
        if (alarm_event === 1'b1) alarm_cnt++;
    end
    // ***********************************************************
    // bus tasks
    // ***********************************************************
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // waits for ready sampled high, bounded so a stuck slave cannot hang
    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 20);
        if (hreadyout !== 1'b1) begin
            miscompares++;
            end_of_test();
        end
        `CHK(hresp, 1'b0)
    endtask
    task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd_v = hrdata;
    endtask
    task automatic cmd(input logic [7:0] code, input logic [15:0] ahi, input logic [15:0] alo);
        ahb_xfer(1'b1, tod_pkg::OFS_ARG_HI, {16'h0, ahi});
        ahb_xfer(1'b1, tod_pkg::OFS_ARG_LO, {16'h0, alo});
        ahb_xfer(1'b1, tod_pkg::OFS_CMD, {24'h0, code});
    endtask
    // runs a command and fetches both result words
    task automatic cmd_rd(input logic [7:0] code);
        cmd(code, 16'h0, 16'h0);
        ahb_xfer(1'b0, tod_pkg::OFS_RES_HI, 32'h0);
        hi_v = rd_v;
        ahb_xfer(1'b0, tod_pkg::OFS_RES_LO, 32'h0);
        lo_v = rd_v;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        ahb_xfer(1'b0, a, 32'h0);
        `CHK(rd_v, e)
    endtask
    // ***********************************************************
    // main sequence
    // ***********************************************************
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        hsize = 3'b010;
        miscompares = 0;
        cmp_count = 0;
        hook_cnt = 0;
        alarm_cnt = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // power-up state: tick near zero, calendar zero, alarm disarmed
        rd_chk(tod_pkg::OFS_STATUS, 32'h0);
        cmd_rd(tod_pkg::FC_READ_TICK);
        `CHK(hi_v, 32'h0)
        `CHK(lo_v < 32'h4, 1'b1)
        rd_chk(tod_pkg::OFS_RES_FLAG, 32'h0);
        cmd_rd(tod_pkg::FC_READ_TIME);
        `CHK(hi_v, 32'h0)
        `CHK(lo_v, 32'h0)
        $display("test reset done");
        // tick set near a half boundary; the low-half carry must reach the high half
        cmd(tod_pkg::FC_SET_TICK, 16'h0001, 16'hffff);
        n = 0;
        do begin
            cmd_rd(tod_pkg::FC_READ_TICK);
            n++;
        end while (lo_v === 32'h0000_ffff && n < 50);
        `CHK({hi_v[15:0], lo_v[15:0]}, 32'h0002_0000)
        `CHK({hi_v[31:16], lo_v[31:16]}, 32'h0)
        rd_chk(tod_pkg::OFS_RES_FLAG, 32'h0);
        cmd_rd(tod_pkg::FC_READ_DAYS);
        `CHK(hi_v, 32'h0000_0002)
        rd_chk(tod_pkg::OFS_RES_FLAG, 32'h0);
        $display("test tick count done");
        // tick hook: a window of ten periods holds exactly ten pulses
        n = hook_cnt;
        repeat (10 * TP) @(posedge hclk);
        `CHK(hook_cnt - n, 10)
        $display("test tick hook done");
        // bcd time wraps from 23:59:59 to 00:00:00 on the next second
        cmd(tod_pkg::FC_SET_TIME, 16'h2359, 16'h5900);
        n = 0;
        do begin
            cmd_rd(tod_pkg::FC_READ_TIME);
            n++;
        end while (lo_v === 32'h0000_5900 && n < 100);
        `CHK({hi_v, lo_v}, 64'h0)
        $display("test time done");
        // date: reset value then a boundary write read back
        cmd_rd(tod_pkg::FC_READ_DATE);
        `CHK({hi_v, lo_v}, 64'h0000_1900_0000_0101)
        cmd(tod_pkg::FC_SET_DATE, 16'h2099, 16'h1231);
        cmd_rd(tod_pkg::FC_READ_DATE);
        `CHK({hi_v, lo_v}, 64'h0000_2099_0000_1231)
        $display("test date done");
        // alarm: accept, refuse while armed, fire once at match
        cmd(tod_pkg::FC_SET_TIME, 16'h0000, 16'h0000);
        cmd(tod_pkg::FC_SET_ALARM, 16'h0000, 16'h0200);
        rd_chk(tod_pkg::OFS_RES_FLAG, 32'h0);
        rd_chk(tod_pkg::OFS_STATUS, 32'h1);
        cmd(tod_pkg::FC_SET_ALARM, 16'h0000, 16'h0500);
        rd_chk(tod_pkg::OFS_RES_FLAG, 32'h100);
        n = 0;
        while (alarm_cnt == 0 && n < 1000) begin
            @(posedge hclk);
            n++;
        end
        `CHK(alarm_cnt, 1)
        cmd_rd(tod_pkg::FC_READ_TIME);
        // the earlier alarm time stands, not the refused one
        `CHK({hi_v, lo_v}, 64'h0000_0000_0000_0200)
        rd_chk(tod_pkg::OFS_STATUS, 32'h0);
        cmd(tod_pkg::FC_SET_ALARM, 16'h0000, 16'h5900);
        rd_chk(tod_pkg::OFS_RES_FLAG, 32'h0);
        cmd(tod_pkg::FC_CANCEL_ALARM, 16'h0, 16'h0);
        rd_chk(tod_pkg::OFS_STATUS, 32'h0);
        cmd(tod_pkg::FC_SET_ALARM, 16'h0000, 16'h5900);
        rd_chk(tod_pkg::OFS_RES_FLAG, 32'h0);
        cmd(tod_pkg::FC_CANCEL_ALARM, 16'h0, 16'h0);
        `CHK(alarm_cnt, 1)
        $display("test alarm done");
        // unmapped place reads zero; an unknown code leaves results alone
        ahb_xfer(1'b1, 8'h1c, 32'hffff_ffff);
        rd_chk(8'h1c, 32'h0);
        cmd(tod_pkg::FC_SET_DATE, 16'h1950, 16'h0615);
        cmd_rd(tod_pkg::FC_READ_DATE);
        cmd(8'h08, 16'h0, 16'h0);
        rd_chk(tod_pkg::OFS_RES_HI, 32'h0000_1950);
        rd_chk(tod_pkg::OFS_RES_LO, 32'h0000_0615);
        $display("test unmapped done");
        // day accounting: each wait leaves a window of whole days plus under one tick
        cmd_rd(tod_pkg::FC_READ_TICK);
        repeat (DT * TP) @(posedge hclk);
        cmd_rd(tod_pkg::FC_READ_TICK);
        rd_chk(tod_pkg::OFS_RES_FLAG, 32'h1);
        cmd_rd(tod_pkg::FC_READ_TICK);
        rd_chk(tod_pkg::OFS_RES_FLAG, 32'h0);
        // three days pass: the flag still only says that a day went by
        repeat (3 * DT * TP) @(posedge hclk);
        cmd_rd(tod_pkg::FC_READ_TICK);
        rd_chk(tod_pkg::OFS_RES_FLAG, 32'h1);
        // beyond one day software asks for the day count instead
        repeat (3 * DT * TP) @(posedge hclk);
        cmd_rd(tod_pkg::FC_READ_DAYS);
        rd_chk(tod_pkg::OFS_RES_FLAG, 32'h3);
        // 260 days without a clearing read stop at the top of the count
        repeat (260 * DT * TP) @(posedge hclk);
        cmd_rd(tod_pkg::FC_READ_DAYS);
        rd_chk(tod_pkg::OFS_RES_FLAG, 32'hff);
        $display("test days done");
        end_of_test();
    end
endmodule
